/* File: logic/iipp_mem.sv */
// iipp_mem: internal command location store, one write and one read port.
// assumes the owner presents the read address a cycle before it needs data.
`timescale 1ns/1ps
`default_nettype none
module iipp_mem
   import iipp_pkg::*;
(
   // clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // write port
   input  wire logic                   we,
   input  wire logic [IIPP_MEM_AW-1:0] waddr,
   input  wire logic [IIPP_MEM_DW-1:0] wdata,
   // read port
   input  wire logic [IIPP_MEM_AW-1:0] raddr,
   output logic      [IIPP_MEM_DW-1:0] rdata_reg
);

   logic [IIPP_MEM_DW-1:0] mem [0:(1<<IIPP_MEM_AW)-1];

   // contents are not reset; locations read garbage until poked
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= mem[raddr];
      end
   end

endmodule : iipp_mem
`default_nettype wire

/* File: logic/iipp_pkg.sv */
// iipp_pkg: constants shared by the indirect peek/poke port and its memory.
// assumes a 32-bit apb register bus and 16-bit internal command locations.
package iipp_pkg;

   // apb byte offsets
   localparam logic [11:0] IIPP_OFS_CMD      = 12'h000;
   localparam logic [11:0] IIPP_OFS_DATA0    = 12'h004;
   localparam logic [11:0] IIPP_OFS_DATA1    = 12'h008;
   localparam logic [11:0] IIPP_OFS_IRQ_STAT = 12'h00c;
   localparam logic [11:0] IIPP_OFS_IRQ_MASK = 12'h010;
   localparam logic [11:0] IIPP_OFS_STATE    = 12'h014;

   // command word layout
   localparam int IIPP_CMD_ID_BIT   = 14;
   localparam int IIPP_CMD_PAGE_HI  = 13;
   localparam int IIPP_CMD_PAGE_LO  = 9;
   localparam int IIPP_CMD_PTR_HI   = 8;
   localparam int IIPP_CMD_PTR_LO   = 0;

   // special command words
   localparam logic [15:0] IIPP_POKE_EN0  = 16'h0bf6;
   localparam logic [15:0] IIPP_POKE_DIS0 = 16'h01f6;
   localparam logic [15:0] IIPP_POKE_EN1  = 16'h4bf6;
   localparam logic [15:0] IIPP_POKE_DIS1 = 16'h41f6;

   // special locations
   localparam logic [8:0] IIPP_LOC_ENERGY  = 9'h0c0;
   localparam logic [8:0] IIPP_LOC_STATUS0 = 9'h02c;
   localparam logic [8:0] IIPP_LOC_STATUS1 = 9'h02d;
   localparam logic [8:0] IIPP_LOC_BYTE_A  = 9'h001;
   localparam logic [8:0] IIPP_LOC_BYTE_B  = 9'h002;
   localparam logic [8:0] IIPP_LOC_BYTE_C  = 9'h0d9;
   localparam logic [8:0] IIPP_LOC_BYTE_D  = 9'h0da;

   // energy block
   localparam logic [15:0] IIPP_BLK_COUNT = 16'h000c;
   localparam logic [2:0]  IIPP_BLK_LAST  = 3'h7;

   // status word bits
   localparam int IIPP_STS_POKE_FAIL = 1;
   localparam int IIPP_STS_BLK_FAIL  = 0;

   // interrupt bits
   localparam int IIPP_IRQ_REJ0  = 0;
   localparam int IIPP_IRQ_REJ1  = 1;
   localparam int IIPP_IRQ_BLKND = 2;
   localparam int IIPP_IRQ_W     = 3;

   // internal memory
   localparam int IIPP_MEM_AW = 11;
   localparam int IIPP_MEM_DW = 16;

endpackage : iipp_pkg

/* File: logic/iipp_top.sv */
// iipp_top: indirect peek/poke port for two hosts, reached over apb.
// assumes energy and elapsed time inputs are synchronous to pclk.
// Functional notes
// - pointer 0xc0 page 0 streams count 0x000c, energy, time, lsw first
// - peek: load pointer, page, host id, then read that host's data port
// - peeks are word reads; byte locations return upper byte zero
// - command 0x0bf6 enables host 0 pokes, 0x01f6 disables them
// - command 0x4bf6 enables host 1 pokes, 0x41f6 disables, independently
// - poke enables persist; cleared only by reset, watchdog input or a disable command
// - poke: write data port, value lands in the referenced location; byte locations keep the low byte, status and block ignore it
// - status location 0x2c shows poke-failed clear after good poke
// - host id 1 gives all operations on data port 1, own poke enable
// - command: id bit 14, page 13:9, pointer 8:0, cached per host
// - status bit 1 set when last poke rejected, cleared otherwise
// - host status words at 0x2c and 0x2d by peek; the poke-fail bits also read back in the state register
// - block reads past the buffer end return zero words
`timescale 1ns/1ps
`default_nettype none
module iipp_top
   import iipp_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   // device inputs
   input  wire logic        watchdog_input_pin,
   input  wire logic [47:0] energy_value,
   input  wire logic [47:0] energy_time,
   // interrupt
   output logic             irq
);

   typedef struct packed {
      logic [1:0][8:0]          ptr;
      logic [1:0][4:0]          page;
      logic [1:0]               poke_en;
      logic [1:0]               poke_fail;
      logic [1:0][2:0]          idx;
      logic [1:0][47:0]         esnap;
      logic [1:0][47:0]         tsnap;
      logic [15:0]              cmd_last;
      logic [IIPP_IRQ_W-1:0]    irq_stat;
      logic [IIPP_IRQ_W-1:0]    irq_mask;
      logic [31:0]              prdata;
      logic                     pslverr;
      logic                     served;
   } iipp_state_t;

   iipp_state_t st_reg;
   iipp_state_t st_next;

   logic                   mem_we;
   logic [IIPP_MEM_AW-1:0] mem_waddr;
   logic [IIPP_MEM_DW-1:0] mem_wdata;
   logic [IIPP_MEM_AW-1:0] mem_raddr;
   logic [IIPP_MEM_DW-1:0] mem_rdata;

   function automatic logic iipp_is_byte(input logic [8:0] p);
      iipp_is_byte = (p == IIPP_LOC_BYTE_A) || (p == IIPP_LOC_BYTE_B) ||
                     (p == IIPP_LOC_BYTE_C) || (p == IIPP_LOC_BYTE_D);
   endfunction : iipp_is_byte

   function automatic logic [IIPP_MEM_AW-1:0] iipp_addr(
      input logic [4:0] pg,
      input logic [8:0] p
   );
      iipp_addr = {pg[1:0], p};
   endfunction : iipp_addr

   function automatic logic [15:0] iipp_blk_word(
      input logic [2:0]  i,
      input logic [47:0] e,
      input logic [47:0] t
   );
      case (i)
         3'h0: iipp_blk_word = IIPP_BLK_COUNT;
         3'h1: iipp_blk_word = e[15:0];
         3'h2: iipp_blk_word = e[31:16];
         3'h3: iipp_blk_word = e[47:32];
         3'h4: iipp_blk_word = t[15:0];
         3'h5: iipp_blk_word = t[31:16];
         3'h6: iipp_blk_word = t[47:32];
         default: iipp_blk_word = 16'h0000;
      endcase
   endfunction : iipp_blk_word

   function automatic logic iipp_is_block(
      input logic [4:0] pg,
      input logic [8:0] p
   );
      iipp_is_block = (p == IIPP_LOC_ENERGY) && (pg == 5'h00);
   endfunction : iipp_is_block

   // the data port being addressed picks its host; id 1 mirrors id 0
   logic       data_hit;
   logic       host;
   logic [4:0] h_page;
   logic [8:0] h_ptr;

   always_comb begin
      data_hit = 1'b0;
      host     = 1'b0;
      if (paddr == IIPP_OFS_DATA0) begin
         data_hit = 1'b1;
      end else if (paddr == IIPP_OFS_DATA1) begin
         data_hit = 1'b1;
         host     = 1'b1;
      end
      h_page    = st_reg.page[host];
      h_ptr     = st_reg.ptr[host];
      mem_raddr = iipp_addr(h_page, h_ptr);
   end

   iipp_mem u_mem (
      .pclk      (pclk),
      .presetn   (presetn),
      .we        (mem_we),
      .waddr     (mem_waddr),
      .wdata     (mem_wdata),
      .raddr     (mem_raddr),
      .rdata_reg (mem_rdata)
   );

   // one wait state: the first access cycle loads prdata, the second ends it
   logic xfer_done;
   assign xfer_done = psel && penable && st_reg.served;
   assign pready    = xfer_done;
   assign prdata    = st_reg.prdata;
   assign pslverr   = st_reg.pslverr;
   assign irq       = |(st_reg.irq_stat & st_reg.irq_mask);

   logic [15:0]           cmd_w;
   logic                  cmd_h;
   logic [15:0]           peek;
   logic                  mapped;
   logic                  rd_block;
   logic [IIPP_IRQ_W-1:0] ev;

   always_comb begin
      st_next   = st_reg;
      mem_we    = 1'b0;
      mem_waddr = iipp_addr(h_page, h_ptr);
      mem_wdata = pwdata[15:0];
      cmd_w     = pwdata[15:0];
      cmd_h     = cmd_w[IIPP_CMD_ID_BIT];
      ev        = '0;
      rd_block  = iipp_is_block(h_page, h_ptr);
      mapped    = (paddr == IIPP_OFS_CMD) || data_hit ||
                  (paddr == IIPP_OFS_IRQ_STAT) ||
                  (paddr == IIPP_OFS_IRQ_MASK) ||
                  (paddr == IIPP_OFS_STATE);

      // peek word of the addressed host
      if (rd_block) begin
         peek = iipp_blk_word(st_reg.idx[host], st_reg.esnap[host],
                              st_reg.tsnap[host]);
      end else if (h_ptr == IIPP_LOC_STATUS0) begin
         peek = 16'h0000;
         peek[IIPP_STS_POKE_FAIL] = st_reg.poke_fail[0];
      end else if (h_ptr == IIPP_LOC_STATUS1) begin
         peek = 16'h0000;
         peek[IIPP_STS_POKE_FAIL] = st_reg.poke_fail[1];
      end else if (iipp_is_byte(h_ptr)) begin
         peek = {8'h00, mem_rdata[7:0]};
      end else begin
         peek = mem_rdata;
      end

      // first access cycle: capture read data and the error answer
      if (psel && penable && !st_reg.served) begin
         st_next.served  = 1'b1;
         st_next.pslverr = !mapped;
         st_next.prdata  = 32'h0000_0000;
         if (!pwrite) begin
            if (paddr == IIPP_OFS_CMD) begin
               st_next.prdata = {16'h0000, st_reg.cmd_last};
            end else if (data_hit) begin
               st_next.prdata = {16'h0000, peek};
            end else if (paddr == IIPP_OFS_IRQ_STAT) begin
               st_next.prdata = {29'h0, st_reg.irq_stat};
            end else if (paddr == IIPP_OFS_IRQ_MASK) begin
               st_next.prdata = {29'h0, st_reg.irq_mask};
            end else if (paddr == IIPP_OFS_STATE) begin
               st_next.prdata = {28'h0, st_reg.poke_fail, st_reg.poke_en};
            end
         end
      end

      // completing edge: side effects of reads and writes
      if (xfer_done) begin
         st_next.served = 1'b0;
         if (!pwrite && data_hit && rd_block) begin
            if (st_reg.idx[host] != IIPP_BLK_LAST) begin
               st_next.idx[host] = st_reg.idx[host] + 3'h1;
            end
            if (st_reg.idx[host] == 3'h6) begin
               ev[IIPP_IRQ_BLKND] = 1'b1;
            end
         end
         if (pwrite) begin
            if (paddr == IIPP_OFS_CMD) begin
               st_next.cmd_last = cmd_w;
               if (cmd_w == IIPP_POKE_EN0) begin
                  st_next.poke_en[0] = 1'b1;
               end else if (cmd_w == IIPP_POKE_DIS0) begin
                  st_next.poke_en[0] = 1'b0;
               end else if (cmd_w == IIPP_POKE_EN1) begin
                  st_next.poke_en[1] = 1'b1;
               end else if (cmd_w == IIPP_POKE_DIS1) begin
                  st_next.poke_en[1] = 1'b0;
               end else begin
                  // pointer and page cached per host id
                  st_next.ptr[cmd_h] =
                     cmd_w[IIPP_CMD_PTR_HI:IIPP_CMD_PTR_LO];
                  st_next.page[cmd_h] =
                     cmd_w[IIPP_CMD_PAGE_HI:IIPP_CMD_PAGE_LO];
                  st_next.idx[cmd_h]   = 3'h0;
                  // snapshot so the six words stay coherent across reads
                  st_next.esnap[cmd_h] = energy_value;
                  st_next.tsnap[cmd_h] = energy_time;
               end
            end else if (data_hit) begin
               if (!st_reg.poke_en[host]) begin
                  st_next.poke_fail[host] = 1'b1;
                  ev[host] = 1'b1;
               end else begin
                  st_next.poke_fail[host] = 1'b0;
                  // status and block locations are read only
                  if (!rd_block && h_ptr != IIPP_LOC_STATUS0 &&
                      h_ptr != IIPP_LOC_STATUS1) begin
                     mem_we = 1'b1;
                     if (iipp_is_byte(h_ptr)) begin
                        mem_wdata = {8'h00, pwdata[7:0]};
                     end
                  end
               end
            end else if (paddr == IIPP_OFS_IRQ_STAT) begin
               st_next.irq_stat = st_reg.irq_stat & ~pwdata[IIPP_IRQ_W-1:0];
            end else if (paddr == IIPP_OFS_IRQ_MASK) begin
               st_next.irq_mask = pwdata[IIPP_IRQ_W-1:0];
            end
         end
      end

      // new events win over a write-one-to-clear in the same cycle
      st_next.irq_stat = st_next.irq_stat | ev;

      // watchdog reset drops enables and caches, as a power-up would
      if (watchdog_input_pin) begin
         st_next.poke_en   = 2'b00;
         st_next.poke_fail = 2'b00;
         st_next.ptr       = '0;
         st_next.page      = '0;
         st_next.idx       = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule : iipp_top
`default_nettype wire

/* File: tb/iipp_energy_src.sv */
// iipp_energy_src: accumulator side that feeds energy and elapsed time.
// assumes both values are held steady between block reads.
`timescale 1ns/1ps
`default_nettype none
module iipp_energy_src #(
   parameter logic [47:0] E_VAL = 48'h0,
   parameter logic [47:0] T_VAL = 48'h0
) (
   // accumulated values
   output logic [47:0] energy_value,
   output logic [47:0] energy_time
);
   assign energy_value = E_VAL;
   assign energy_time  = T_VAL;
endmodule : iipp_energy_src
`default_nettype wire

/* File: tb/iipp_top_assertions.sv */
// iipp_top_assertions: apb timing, refusal and irq checks.
// assumes it is bound to iipp_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module iipp_top_assertions
   import iipp_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // device side
   input wire logic        watchdog_input_pin,
   input wire logic [47:0] energy_value,
   input wire logic [47:0] energy_time,
   input wire logic        irq
);
   logic rdx;
   logic mapped;
   logic wd;
   assign rdx = pready && !pwrite;
   assign mapped = paddr <= IIPP_OFS_STATE && paddr[1:0] == 2'h0;
   assign wd = watchdog_input_pin;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_map: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not match address map");
   a_err_zero: assert property (rdx && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_port_upper: assert property (rdx && (paddr == IIPP_OFS_DATA0 ||
      paddr == IIPP_OFS_DATA1) |-> prdata[31:16] == 16'h0)
      else $error("data port upper half not zero");
   a_wdog_clear: assert property (wd && $past(wd) && $past(wd, 2) && rdx &&
      paddr == IIPP_OFS_STATE |-> prdata[3:0] == 4'h0)
      else $error("poke state survives watchdog");
   a_mask_off: assert property (pready && pwrite && paddr == IIPP_OFS_IRQ_MASK
      && pwdata[2:0] == 3'h0 |=> !irq)
      else $error("irq with all masked");
   a_stat_clear: assert property (pready && pwrite &&
      paddr == IIPP_OFS_IRQ_STAT && pwdata[2:0] == 3'h7 |=> !irq)
      else $error("irq after full clear");
   c_err: cover property (pslverr);
   c_irq: cover property (irq);
   c_poke1: cover property (pready && pwrite && paddr == IIPP_OFS_DATA1);
endmodule : iipp_top_assertions
bind iipp_top iipp_top_assertions u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .watchdog_input_pin,
   .energy_value, .energy_time, .irq);
`default_nettype wire

/* File: tb/indirect_peek_poke_port_test.sv */
// indirect_peek_poke_port_test: apb sequences against iipp_top.
// assumes one wait state is not relied on; waits are bounded.
`timescale 1ns/1ps
`default_nettype none
module indirect_peek_poke_port_test;
   import iipp_pkg::*;
   localparam logic [47:0] EV = 48'h3456_789a_bcde;
   localparam logic [47:0] ET = 48'h0102_0304_0506;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic        wdog    = 1'b0;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        rerr;
   logic [31:0] prdata;
   logic [31:0] rdat;
   logic [47:0] ev;
   logic [47:0] et;
   logic [15:0] blk [8];
   int          miscompares = 0;
   int          tests_run = 0;
   always #4 pclk = ~pclk;
   iipp_energy_src #(.E_VAL(EV), .T_VAL(ET)) src (.energy_value(ev),
      .energy_time(et));
   iipp_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .watchdog_input_pin(wdog),
      .energy_value(ev), .energy_time(et), .irq);
   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready and read data are taken at the rising edge that ends the access
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 16) begin
         miscompares++;
         wrap_up();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0, d});
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rd
   task irqchk(input logic e);
      @(posedge pclk);
      chk({31'h0, irq}, {31'h0, e});
   endtask : irqchk
   initial begin
      blk = '{16'h000c, EV[15:0], EV[31:16], EV[47:32],
         ET[15:0], ET[31:16], ET[47:32], 16'h0};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(IIPP_OFS_STATE, 32'h0);
      rd(IIPP_OFS_IRQ_MASK, 32'h0);
      wr(IIPP_OFS_CMD, 16'h0210);
      wr(IIPP_OFS_DATA0, 16'h1234);
      rd(IIPP_OFS_STATE, 32'h4);
      wr(IIPP_OFS_CMD, {7'h0, IIPP_LOC_STATUS0});
      rd(IIPP_OFS_DATA0, 32'h2);
      wr(IIPP_OFS_IRQ_MASK, 16'h7);
      irqchk(1'b1);
      wr(IIPP_OFS_IRQ_STAT, 16'h7);
      irqchk(1'b0);
      $display("test rejected poke finished");
      wr(IIPP_OFS_CMD, IIPP_POKE_EN0);
      rd(IIPP_OFS_STATE, 32'h5);
      wr(IIPP_OFS_CMD, 16'h0210);
      wr(IIPP_OFS_DATA0, 16'hbeef);
      rd(IIPP_OFS_DATA0, 32'hbeef);
      wr(IIPP_OFS_CMD, {7'h0, IIPP_LOC_STATUS0});
      rd(IIPP_OFS_DATA0, 32'h0);
      wr(IIPP_OFS_CMD, IIPP_POKE_EN1);
      rd(IIPP_OFS_STATE, 32'h3);
      wr(IIPP_OFS_CMD, IIPP_POKE_DIS0);
      rd(IIPP_OFS_STATE, 32'h2);
      wr(IIPP_OFS_CMD, 16'h4211);
      wr(IIPP_OFS_DATA1, 16'h5a5a);
      rd(IIPP_OFS_DATA1, 32'h5a5a);
      wr(IIPP_OFS_CMD, 16'h0210);
      wr(IIPP_OFS_DATA0, 16'h1111);
      rd(IIPP_OFS_DATA0, 32'hbeef);
      rd(IIPP_OFS_STATE, 32'h6);
      wr(IIPP_OFS_CMD, {7'h20, IIPP_LOC_BYTE_C});
      wr(IIPP_OFS_DATA1, 16'habcd);
      rd(IIPP_OFS_DATA1, 32'hcd);
      $display("test pokes finished");
      wr(IIPP_OFS_CMD, {7'h0, IIPP_LOC_ENERGY});
      for (int i = 0; i < 8; i++)
         rd(IIPP_OFS_DATA0, {16'h0, blk[i]});
      rd(IIPP_OFS_IRQ_STAT, 32'h5);
      wr(IIPP_OFS_IRQ_STAT, 16'h7);
      $display("test energy block finished");
      @(posedge pclk);
      wdog <= 1'b1;
      rd(IIPP_OFS_STATE, 32'h0);
      @(posedge pclk);
      wdog <= 1'b0;
      rd(IIPP_OFS_STATE, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk(rdat, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      wr(IIPP_OFS_CMD, 16'h0210);
      wr(IIPP_OFS_DATA0, 16'h2222);
      irqchk(1'b1);
      rd(IIPP_OFS_DATA0, 32'hbeef);
      wr(IIPP_OFS_IRQ_MASK, 16'h0);
      irqchk(1'b0);
      $display("test watchdog and map finished");
      wrap_up();
   end
endmodule : indirect_peek_poke_port_test
`default_nettype wire
